/* hdl/char_lcd_instruction_decoder.sv */
// instruction decoder, transfer fifo and display/glyph rams of a character display
//
// How it works
// - host transfers are latched as instruction or data, executed later internally.
// - each ram data access steps the address pointer by one per entry direction.
// - a status read shows busy high on line 7 during execution.
// - clear fills display ram with 20H, address 00H, within 1.53ms.
// - home loads address 00H, undoes display shift, keeps display ram.
// - entry instruction stores direction and follow bits, 39us.
// - on/off instruction stores display, cursor and blink bits in order.
// - shift instruction moves cursor or display, ram untouched, 39us.
// - function instruction stores bus width, line count and font, 39us.
// - glyph address instruction loads pointer, selects glyph ram, 39us.
// - display address instruction loads pointer, selects display ram, 39us.
// - status read returns busy and 7-bit pointer, answered even when busy.
// - data write stores the byte into the last addressed ram, 43us.
// - data read returns a byte from the last addressed ram, 43us.
// - bus width bit high means 8-bit transfers, low 4-bit.
// - in 4-bit mode each byte is two nibbles on the upper lines.
// - two-line mode display addresses run 00H-27H and 40H-67H.
// - direction high moves the cursor right, pointer plus one.

module xfer_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input  wire logic         ref_clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] in_data_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  output logic [W-1:0]      out_data_o,
  output logic              out_valid_o,
  input  wire logic         out_ready_i
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_q [D];
  logic [AW:0]  wp_q;
  logic [AW:0]  rp_q;
  wire          full  = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
  wire          empty = (wp_q == rp_q);
  wire          push  = in_valid_i && !full;
  wire          pop   = out_ready_i && !empty;
  assign in_ready_o  = !full;
  assign out_valid_o = !empty;
  assign out_data_o  = mem_q[rp_q[AW-1:0]];
  always_ff @(posedge ref_clk_i) begin
    if (push) mem_q[wp_q[AW-1:0]] <= in_data_i;
  end
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      if (push) wp_q <= wp_q + 1'b1;
      if (pop) rp_q <= rp_q + 1'b1;
    end
  end
endmodule : xfer_fifo

`include "lcd_regs.svh"

module char_lcd_instruction_decoder
  import lcd_pkg::*;
#(
  parameter int OSC_KHZ   = `OSC_REF_KHZ,
  parameter int CLEAR_CYC = `T_CLEAR_NS * `OSC_REF_KHZ / (OSC_KHZ * `CLK_PERIOD_NS),
  parameter int DATA_CYC  = `T_DATA_NS * `OSC_REF_KHZ / (OSC_KHZ * `CLK_PERIOD_NS)
) (
  input  wire logic       ref_clk_i,
  input  wire logic       rst_i,
  input  wire logic       reg_select_i,
  input  wire logic       rw_i,
  input  wire logic       enable_i,
  input  wire logic [7:0] parallel_bus_lines_i,
  output logic [7:0]      parallel_bus_lines_o,
  output logic [7:0]      parallel_bus_lines_oe_n_o,
  output logic            busy_indicator_o,
  output logic [6:0]      address_pointer_o,
  output logic            target_glyph_o,
  output logic            display_on_o,
  output logic            cursor_on_o,
  output logic            blink_on_o,
  output logic            entry_inc_o,
  output logic            display_follow_o,
  output logic            bus_width_o,
  output logic            two_line_o,
  output logic            font_tall_o,
  output logic [5:0]      display_offset_o
);
  localparam int SHORT_CYC = `T_SHORT_NS * `OSC_REF_KHZ / (OSC_KHZ * `CLK_PERIOD_NS);

  function automatic logic [6:0] step_addr(input logic [6:0] a, input logic up,
                                           input logic cg, input logic two);
    if (cg) return {1'b0, up ? 6'(a[5:0] + 6'h01) : 6'(a[5:0] - 6'h01)};
    if (two && up) return (a == `L1_END) ? `L2_START : (a == `L2_END) ? `ADDR_HOME : 7'(a + 7'h01);
    if (two) return (a == `ADDR_HOME) ? `L2_END : (a == `L2_START) ? `L1_END : 7'(a - 7'h01);
    if (up) return (a == `ONE_LINE_END) ? `ADDR_HOME : 7'(a + 7'h01);
    return (a == `ADDR_HOME) ? `ONE_LINE_END : 7'(a - 7'h01);
  endfunction : step_addr

  function automatic logic [5:0] step_ofs(input logic [5:0] o, input logic left);
    if (left) return (o == `OFS_MAX) ? 6'h00 : 6'(o + 6'h01);
    return (o == 6'h00) ? `OFS_MAX : 6'(o - 6'h01);
  endfunction : step_ofs

  logic [7:0]  dd_q [`DD_WORDS];
  logic [7:0]  cg_ram_q [`CG_WORDS];
  logic        e_q, nib_q, pend_q, busy_q, clr_q;
  logic [3:0]  hi_q;
  logic [9:0]  pend_w_q;
  logic [7:0]  rd_buf_q, rdv_q, bus_q;
  logic [7:0]  oe_n_q;
  logic [6:0]  ac_q, clr_idx_q;
  logic [5:0]  ofs_q;
  logic        cg_q, don_q, con_q, bon_q, inc_q, fol_q, dl_q, two_q, fnt_q;
  logic [17:0] cnt_q;
  exec_state_t st_q;
  logic        in_ready, h_valid;
  logic [9:0]  h_word;

  // host side: strobe edges, nibble pairing, latching
  wire        e_rise    = enable_i && !e_q;
  wire        e_fall    = e_q && !enable_i;
  wire        last_nib  = dl_q || nib_q;
  wire [7:0]  wr_byte   = dl_q ? parallel_bus_lines_i : {hi_q, parallel_bus_lines_i[7:4]};
  wire [7:0]  stat_byte = {busy_q, ac_q};
  wire [7:0]  rd_val    = reg_select_i ? rd_buf_q : stat_byte;
  wire        latch     = e_fall && last_nib && (!rw_i || reg_select_i);
  xfer_kind_t lk;
  assign lk = rw_i ? K_RD : (reg_select_i ? K_WR : K_INS);

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      e_q    <= 1'b0;
      nib_q  <= 1'b0;
      hi_q   <= 4'h0;
      rdv_q  <= 8'h00;
      bus_q  <= 8'h00;
      oe_n_q <= 8'hFF;
    end else begin
      e_q    <= enable_i;
      oe_n_q <= {8{!(enable_i && rw_i)}};
      if (e_fall && !dl_q) nib_q <= !nib_q;
      if (e_fall && !dl_q && !nib_q) hi_q <= parallel_bus_lines_i[7:4];
      if (e_rise && rw_i && !(!dl_q && nib_q)) begin
        rdv_q <= rd_val;
        bus_q <= rd_val;
      end else if (e_rise && rw_i) begin
        bus_q <= {rdv_q[3:0], 4'h0};
      end
    end
  end

  // one word waits here while the fifo is full; a second latch then overwrites it
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      pend_q   <= 1'b0;
      pend_w_q <= 10'h000;
    end else if (latch) begin
      pend_q   <= 1'b1;
      pend_w_q <= {lk, wr_byte};
    end else if (in_ready) begin
      pend_q   <= 1'b0;
    end
  end

  xfer_fifo #(.W(`FIFO_W), .D(`FIFO_D)) u_fifo (
    .ref_clk_i   (ref_clk_i),
    .rst_i       (rst_i),
    .in_data_i   (pend_w_q),
    .in_valid_i  (pend_q),
    .in_ready_o  (in_ready),
    .out_data_o  (h_word),
    .out_valid_o (h_valid),
    .out_ready_i (st_q == ST_IDLE)
  );

  // executor decode of the fifo head
  wire [7:0] hb     = h_word[7:0];
  wire       pop    = h_valid && (st_q == ST_IDLE);
  wire       p_ins  = pop && (h_word[9:8] == K_INS);
  wire       p_wr   = pop && (h_word[9:8] == K_WR);
  wire       p_rd   = pop && (h_word[9:8] == K_RD);
  wire       i_clr  = p_ins && (hb == `OP_CLEAR);
  wire       i_home = p_ins && (hb[7:1] == 7'h01);
  wire       i_ent  = p_ins && (hb[7:2] == 6'h01);
  wire       i_onf  = p_ins && (hb[7:3] == 5'h01);
  wire       i_sh   = p_ins && (hb[7:4] == 4'h1);
  wire       i_fn   = p_ins && (hb[7:5] == 3'h1);
  wire       i_cg   = p_ins && (hb[7:6] == 2'h1);
  wire       i_dd   = p_ins && hb[7];
  wire       slow   = i_clr || i_home;
  wire       data_x = p_wr || p_rd;
  wire [6:0] ac_nx  = step_addr(ac_q, inc_q, cg_q, two_q);
  wire       dd_we  = clr_q || (p_wr && !cg_q);
  wire [6:0] dd_wa  = clr_q ? clr_idx_q : ac_q;
  wire [7:0] dd_wd  = clr_q ? `SPACE_CODE : hb;
  wire       done   = (st_q == ST_EXEC) && (cnt_q == 18'd1);
  wire       run_nx = pop || ((st_q == ST_EXEC) && !done);

  always_ff @(posedge ref_clk_i) begin
    if (dd_we) dd_q[dd_wa] <= dd_wd;
    if (p_wr && cg_q) cg_ram_q[ac_q[5:0]] <= hb;
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      st_q  <= ST_IDLE;
      cnt_q <= 18'd0;
    end else begin
      unique case (st_q)
        ST_IDLE: if (pop) begin
          st_q  <= ST_EXEC;
          cnt_q <= slow ? 18'(CLEAR_CYC) : data_x ? 18'(DATA_CYC) : 18'(SHORT_CYC);
        end
        ST_EXEC: begin
          cnt_q <= cnt_q - 18'd1;
          if (done) st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // busy covers the pending word, queued words and the running instruction
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) busy_q <= 1'b0;
    else busy_q <= latch || pend_q || h_valid || run_nx;
  end

  // clear sweeps every display ram word while its time runs
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      clr_q     <= 1'b0;
      clr_idx_q <= 7'h00;
    end else if (i_clr) begin
      clr_q     <= 1'b1;
      clr_idx_q <= 7'h00;
    end else if (clr_q) begin
      clr_q     <= (clr_idx_q != `CLR_LAST);
      clr_idx_q <= clr_idx_q + 7'h01;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ac_q <= `ADDR_HOME;
      cg_q <= 1'b0;
      ofs_q <= 6'h00;
      rd_buf_q <= 8'h00;
      {don_q, con_q, bon_q} <= 3'b000;
      {inc_q, fol_q} <= 2'b10;
      {dl_q, two_q, fnt_q} <= 3'b100;
    end else begin
      if (i_clr) begin
        ac_q  <= `ADDR_HOME;
        cg_q  <= 1'b0;
        ofs_q <= 6'h00;
        inc_q <= 1'b1;
      end
      if (i_home) begin
        ac_q  <= `ADDR_HOME;
        cg_q  <= 1'b0;
        ofs_q <= 6'h00;
      end
      if (i_ent) {inc_q, fol_q} <= hb[1:0];
      if (i_onf) {don_q, con_q, bon_q} <= hb[2:0];
      if (i_sh && !hb[3]) ac_q <= step_addr(ac_q, hb[2], cg_q, two_q);
      if (i_sh && hb[3]) ofs_q <= step_ofs(ofs_q, !hb[2]);
      if (i_fn) {dl_q, two_q, fnt_q} <= hb[4:2];
      if (i_cg) begin
        ac_q <= {1'b0, hb[5:0]};
        cg_q <= 1'b1;
      end
      if (i_dd) begin
        ac_q <= hb[6:0];
        cg_q <= 1'b0;
      end
      if (data_x) ac_q <= ac_nx;
      if (p_rd) rd_buf_q <= cg_q ? cg_ram_q[ac_q[5:0]] : dd_q[ac_q];
      if (p_wr && fol_q && !cg_q) ofs_q <= step_ofs(ofs_q, inc_q);
    end
  end

  assign parallel_bus_lines_o      = bus_q;
  assign parallel_bus_lines_oe_n_o = oe_n_q;
  assign busy_indicator_o          = busy_q;
  assign address_pointer_o         = ac_q;
  assign target_glyph_o            = cg_q;
  assign display_on_o              = don_q;
  assign cursor_on_o               = con_q;
  assign blink_on_o                = bon_q;
  assign entry_inc_o               = inc_q;
  assign display_follow_o          = fol_q;
  assign bus_width_o               = dl_q;
  assign two_line_o                = two_q;
  assign font_tall_o               = fnt_q;
  assign display_offset_o          = ofs_q;
  sequence clear_end_s;
    !cg_q && (ac_q == `ADDR_HOME) && (ofs_q == 6'h00) && inc_q && clr_q;
  endsequence
  sequence short_run_s;
    busy_q [*8];
  endsequence
  latch_busy_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    latch |=> busy_q) else $error("busy not raised after latch");
  entry_hold_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    i_ent |=> (inc_q == $past(hb[1])) && (fol_q == $past(hb[0])) ##1 short_run_s)
    else $error("entry bits or busy wrong");
  status_read_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (e_rise && rw_i && !reg_select_i && dl_q) |=> bus_q == $past(stat_byte))
    else $error("status byte wrong");
  clear_done_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (i_clr && CLEAR_CYC > 130) |=> clr_q ##128 !clr_q && dd_q[`CLR_LAST] == `SPACE_CODE)
    else $error("clear sweep wrong");
  clear_pos_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    i_clr |=> clear_end_s) else $error("clear end state wrong");
  home_ac_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    i_home |=> ac_q == `ADDR_HOME && ofs_q == 6'h00 && !cg_q) else $error("home wrong");
  onoff_bits_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    i_onf |=> {don_q, con_q, bon_q} == $past(hb[2:0])) else $error("on/off bits wrong");
  func_bits_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    i_fn |=> {dl_q, two_q, fnt_q} == $past(hb[4:2])) else $error("function bits wrong");
  glyph_set_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    i_cg |=> cg_q && ac_q == {1'b0, $past(hb[5:0])}) else $error("glyph address wrong");
  disp_set_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    i_dd |=> !cg_q && ac_q == $past(hb[6:0])) else $error("display address wrong");
  line_wrap_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (data_x && two_q && inc_q && !cg_q && ac_q == `L1_END) |=> ac_q == `L2_START)
    else $error("line wrap wrong");
  step_up_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (p_wr && inc_q && cg_q) |=> ac_q[5:0] == 6'($past(ac_q[5:0]) + 6'h01))
    else $error("pointer not stepped");
endmodule : char_lcd_instruction_decoder

/* hdl/lcd_pkg.sv */
// types shared by the character display instruction decoder
package lcd_pkg;
  typedef enum logic [1:0] {K_INS, K_WR, K_RD} xfer_kind_t;
  typedef enum logic {ST_IDLE, ST_EXEC} exec_state_t;
endpackage : lcd_pkg

/* hdl/lcd_regs.svh */
// constants of the character display instruction decoder
`ifndef LCD_DEC_REGS_SVH
`define LCD_DEC_REGS_SVH
`define CLK_PERIOD_NS  10
`define OSC_REF_KHZ    270
`define T_CLEAR_NS     1530000
`define T_SHORT_NS     39000
`define T_DATA_NS      43000
`define SPACE_CODE     8'h20
`define ADDR_HOME      7'h00
`define L1_END         7'h27
`define L2_START       7'h40
`define L2_END         7'h67
`define ONE_LINE_END   7'h4F
`define OFS_MAX        6'h27
`define DD_WORDS       128
`define CG_WORDS       64
`define CLR_LAST       7'h7F
`define FIFO_W         10
`define FIFO_D         8
`define OP_CLEAR       8'h01
`endif

/* verification/lcd_host_model.sv */
// host processor model that strobes the display decoder's parallel bus
module lcd_host_model #(
  parameter int HALF_OSC_CYC = 185
) (
  input  wire logic       ref_clk_i,
  input  wire logic [7:0] bus_dev_i,
  input  wire logic [7:0] bus_oe_n_i,
  output logic            reg_select_o,
  output logic            rw_o,
  output logic            enable_o,
  output logic [7:0]      bus_host_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic nib_mode = 1'b0;
  initial begin
    reg_select_o = 1'b0;
    rw_o         = 1'b0;
    enable_o     = 1'b0;
    bus_host_o   = 8'h00;
  end
  // enable high two cycles then low two; released lines flip so no stale value survives
  task automatic strobe(input logic rs, input logic rd, input logic [7:0] v,
                        output logic [7:0] got);
    @(posedge ref_clk_i);
    #1;
    reg_select_o = rs;
    rw_o         = rd;
    bus_host_o   = rd ? ~bus_host_o : v;
    enable_o     = 1'b1;
    repeat (2) @(posedge ref_clk_i);
    got = (bus_oe_n_i === 8'h00) ? bus_dev_i : ~bus_dev_i;
    #1;
    enable_o = 1'b0;
    // write data stays through the edge that sees enable low, where it is latched
    @(posedge ref_clk_i);
    #1;
    bus_host_o = ~bus_host_o;
    @(posedge ref_clk_i);
  endtask : strobe
  task automatic xfer(input logic rs, input logic rd, input logic [7:0] v,
                      output logic [7:0] got);
    logic [7:0] hi;
    logic [7:0] lo;
    if (nib_mode) begin
      strobe(rs, rd, {v[7:4], 4'h0}, hi);
      strobe(rs, rd, {v[3:0], 4'h0}, lo);
      got = {hi[7:4], lo[7:4]};
    end else begin
      strobe(rs, rd, v, got);
    end
  endtask : xfer
  // poll busy, then leave half an oscillator period before the next strobe
  task automatic wait_ready;
    logic [7:0] s;
    s = 8'hFF;
    for (int i = 0; i < 3000 && s[7] !== 1'b0; i++) begin
      xfer(1'b0, 1'b1, 8'h00, s);
    end
    repeat (HALF_OSC_CYC) @(posedge ref_clk_i);
  endtask : wait_ready
  task automatic send(input logic rs, input logic [7:0] v);
    logic [7:0] g;
    xfer(rs, 1'b0, v, g);
    wait_ready();
  endtask : send
  task automatic fetch(output logic [7:0] got);
    xfer(1'b1, 1'b1, 8'h00, got);
    wait_ready();
  endtask : fetch
endmodule : lcd_host_model

/* verification/tb_char_lcd_instruction_decoder.sv */
// self-checking bench for the character display instruction decoder
module tb_char_lcd_instruction_decoder;
  timeunit 1ns;
  timeprecision 100ps;
  logic       ref_clk_i = 1'b0;
  logic       rst_i     = 1'b1;
  logic       rs, rw, en, busy, glyph, d_on, c_on, blink, inc, follow, width, two, font;
  logic [7:0] bus_in, bus_out, oe_n;
  logic [6:0] ptr;
  logic [5:0] ofs;
  int         err_total = 0;
  int         n_compared = 0;
  always #5 ref_clk_i = ~ref_clk_i;
  char_lcd_instruction_decoder #(.CLEAR_CYC(200), .DATA_CYC(20)) i_char_lcd_instruction_decoder (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .reg_select_i(rs), .rw_i(rw), .enable_i(en),
    .parallel_bus_lines_i(bus_in), .parallel_bus_lines_o(bus_out),
    .parallel_bus_lines_oe_n_o(oe_n), .busy_indicator_o(busy), .address_pointer_o(ptr),
    .target_glyph_o(glyph), .display_on_o(d_on), .cursor_on_o(c_on), .blink_on_o(blink),
    .entry_inc_o(inc), .display_follow_o(follow), .bus_width_o(width), .two_line_o(two),
    .font_tall_o(font), .display_offset_o(ofs));
  lcd_host_model i_lcd_host_model (.ref_clk_i(ref_clk_i), .bus_dev_i(bus_out),
    .bus_oe_n_i(oe_n), .reg_select_o(rs), .rw_o(rw), .enable_o(en), .bus_host_o(bus_in));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("compared=%0d mismatches=%0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop
  // busy shows on a status read at once and lasts the instruction's own count
  task automatic time_exec(input logic rs_v, input logic [7:0] v, input int cyc);
    logic [7:0] s;
    int         n;
    n = 0;
    i_lcd_host_model.xfer(rs_v, 1'b0, v, s);
    i_lcd_host_model.xfer(1'b0, 1'b1, 8'h00, s);
    chk({7'h00, s[7]}, 8'h01);
    while (busy !== 1'b0 && n < 200000) begin
      @(posedge ref_clk_i);
      n++;
    end
    chk({7'h00, 1'(n >= cyc - 10 && n <= cyc + 2)}, 8'h01);
    i_lcd_host_model.wait_ready();
  endtask : time_exec
  task automatic t_clear;
    logic [7:0] g;
    time_exec(1'b0, 8'h01, 200);
    i_lcd_host_model.xfer(1'b0, 1'b1, 8'h00, g);
    chk(g, 8'h00);
    i_lcd_host_model.send(1'b0, 8'hE7);
    i_lcd_host_model.fetch(g);
    i_lcd_host_model.fetch(g);
    chk(g, 8'h20);
  endtask : t_clear
  task automatic t_modes;
    logic [7:0] onoff [3] = '{8'h0C, 8'h0A, 8'h09};
    i_lcd_host_model.send(1'b0, 8'h3C);
    chk({5'h00, width, two, font}, 8'h07);
    i_lcd_host_model.send(1'b0, 8'h38);
    chk({5'h00, width, two, font}, 8'h06);
    time_exec(1'b0, 8'h06, 3900);
    chk({6'h00, inc, follow}, 8'h02);
    foreach (onoff[i]) begin
      i_lcd_host_model.send(1'b0, onoff[i]);
      chk({5'h00, d_on, c_on, blink}, {5'h00, onoff[i][2:0]});
    end
  endtask : t_modes
  task automatic t_data;
    logic [7:0] g;
    i_lcd_host_model.send(1'b0, 8'hA7);
    chk({glyph, ptr}, 8'h27);
    time_exec(1'b1, 8'h41, 20);
    chk({glyph, ptr}, 8'h40);
    i_lcd_host_model.send(1'b0, 8'hA7);
    i_lcd_host_model.fetch(g);
    i_lcd_host_model.fetch(g);
    chk(g, 8'h41);
    i_lcd_host_model.send(1'b0, 8'h45);
    chk({glyph, ptr}, 8'h85);
    i_lcd_host_model.send(1'b1, 8'h1F);
    chk({glyph, ptr}, 8'h86);
  endtask : t_data
  task automatic t_shift;
    i_lcd_host_model.send(1'b0, 8'h80);
    i_lcd_host_model.send(1'b0, 8'h18);
    chk({ofs, ptr[1:0]}, 8'h04);
    i_lcd_host_model.send(1'b0, 8'h14);
    chk({1'b0, ptr}, 8'h01);
    time_exec(1'b0, 8'h02, 200);
    chk({ofs, ptr[1:0]}, 8'h00);
  endtask : t_shift
  // mode switch is not polled in 8-bit form: the nibble phase must start clean
  task automatic t_nibble;
    logic [7:0] g;
    i_lcd_host_model.xfer(1'b0, 1'b0, 8'h28, g);
    i_lcd_host_model.nib_mode = 1'b1;
    i_lcd_host_model.wait_ready();
    chk({7'h00, width}, 8'h00);
    i_lcd_host_model.send(1'b0, 8'h85);
    i_lcd_host_model.xfer(1'b0, 1'b1, 8'h00, g);
    chk(g, 8'h05);
    i_lcd_host_model.send(1'b1, 8'h5A);
    i_lcd_host_model.send(1'b0, 8'h85);
    i_lcd_host_model.fetch(g);
    i_lcd_host_model.fetch(g);
    chk(g, 8'h5A);
  endtask : t_nibble
  // eight data writes go out back to back without polling; the queue must keep them all
  task automatic t_fifo;
    logic [7:0] g;
    i_lcd_host_model.send(1'b0, 8'h80);
    for (int k = 0; k < 8; k++) begin
      i_lcd_host_model.xfer(1'b1, 1'b0, 8'hB0 + 8'(k), g);
    end
    chk({7'h00, busy}, 8'h01);
    i_lcd_host_model.wait_ready();
    chk({1'b0, ptr}, 8'h08);
    i_lcd_host_model.send(1'b0, 8'h80);
    i_lcd_host_model.fetch(g);
    for (int k = 0; k < 8; k++) begin
      i_lcd_host_model.fetch(g);
      chk(g, 8'hB0 + 8'(k));
    end
  endtask : t_fifo
  initial begin
    repeat (90000) @(posedge ref_clk_i);
    err_total++;
    report_and_stop();
  end
  initial begin
    repeat (4) @(posedge ref_clk_i);
    #1;
    rst_i = 1'b0;
    chk({busy, width, inc, d_on, c_on, blink, follow, two}, 8'h60);
    chk(oe_n, 8'hFF);
    t_clear();
    t_fifo();
    t_modes();
    t_data();
    t_shift();
    t_nibble();
    report_and_stop();
  end
endmodule : tb_char_lcd_instruction_decoder
